// >>> logic/ssd_pkg.sv
// Package for the store-mode sequence host controller.
// Assumes one 250 MHz system clock and an asynchronous SRAM on the far side.
package ssd_pkg;
    // ************************************************************
    // Sequence addresses and timing
    // ************************************************************
    localparam int unsigned ADDR_WIDTH = 19;
    localparam int unsigned DATA_WIDTH = 16;
    localparam logic [15:0] SEQ_ADDR_0 = 16'h4E38;
    localparam logic [15:0] SEQ_ADDR_1 = 16'hB1C7;
    localparam logic [15:0] SEQ_ADDR_2 = 16'h83E0;
    localparam logic [15:0] SEQ_ADDR_3 = 16'h7C1F;
    localparam logic [15:0] SEQ_ADDR_4 = 16'h703F;
    localparam logic [15:0] SEQ_ADDR_DIS = 16'h8B45;
    localparam logic [15:0] SEQ_ADDR_EN = 16'h4B46;
    localparam logic [15:0] SEQ_ADDR_STORE = 16'h8FC0;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned READ_CYCLE_NS = 45;
    localparam logic [3:0] READ_CYCLES = 4'((READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [2:0] LAST_STEP = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_PULSE = 3'b010,
        ST_GAP   = 3'b011,
        ST_DONE  = 3'b100
    } ssd_state_type;

    typedef struct packed {
        logic                    ce_n;
        logic                    oe_n;
        logic                    we_n;
        logic [ADDR_WIDTH-1:0]   addr;
    } ssd_pins_type;
endpackage : ssd_pkg

// >>> logic/ssd_host.sv
// Host that issues six-read mode sequences and a closing store to an SRAM.
// Assumes the pin inputs are synchronous to clk_sys and that the SRAM is idle otherwise.
module ssd_host (
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    input  wire logic                           clk_en,
    input  wire logic                           cmd_valid,
    input  wire logic                           cmd_enable,
    output logic                                cmd_ready,
    output logic                                cmd_done,
    input  wire logic                           hardware_store_busy_n,
    output ssd_pkg::ssd_pins_type               sram_pins,
    input  wire logic [ssd_pkg::DATA_WIDTH-1:0] sram_dq_in
);
    // ************************************************************
    // Sequencer state
    // ************************************************************
    ssd_pkg::ssd_state_type state_reg, state_next;
    logic [2:0] step_reg, step_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       enable_reg, enable_next;
    logic       store_reg, store_next;
    logic       done_reg, done_next;
    ssd_pkg::ssd_pins_type pins_reg, pins_next;

    wire        cnt_zero = (cnt_reg == 4'h0);
    wire        last_step = (step_reg == ssd_pkg::LAST_STEP);
    wire [15:0] final_addr = store_reg ? ssd_pkg::SEQ_ADDR_STORE :
                             (enable_reg ? ssd_pkg::SEQ_ADDR_EN : ssd_pkg::SEQ_ADDR_DIS);
    wire [15:0] step_addr = (step_reg == 3'h0) ? ssd_pkg::SEQ_ADDR_0 :
                            (step_reg == 3'h1) ? ssd_pkg::SEQ_ADDR_1 :
                            (step_reg == 3'h2) ? ssd_pkg::SEQ_ADDR_2 :
                            (step_reg == 3'h3) ? ssd_pkg::SEQ_ADDR_3 :
                            (step_reg == 3'h4) ? ssd_pkg::SEQ_ADDR_4 : final_addr;

    assign cmd_ready = (state_reg == ssd_pkg::ST_IDLE);
    assign cmd_done = done_reg;
    assign sram_pins = pins_reg;
    // Read data is not used: the sequence reads only have to take place, their data is dummy.

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // The device is idle only while its busy line is high, so each read waits for it;
    // no other access is let in between steps so the sequence is never aborted.
    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        cnt_next = cnt_reg;
        enable_next = enable_reg;
        store_next = store_reg;
        done_next = 1'b0;
        pins_next = pins_reg;
        pins_next.we_n = 1'b1;
        case (state_reg)
            ssd_pkg::ST_IDLE: begin
                pins_next.ce_n = 1'b1;
                pins_next.oe_n = 1'b1;
                if (cmd_valid) begin
                    enable_next = cmd_enable;
                    store_next = 1'b0;
                    step_next = 3'h0;
                    state_next = ssd_pkg::ST_WAIT;
                end
            end
            ssd_pkg::ST_WAIT: begin
                if (hardware_store_busy_n) begin
                    pins_next.addr = {3'h0, step_addr};
                    pins_next.ce_n = 1'b0;
                    pins_next.oe_n = 1'b0;
                    cnt_next = ssd_pkg::READ_CYCLES;
                    state_next = ssd_pkg::ST_PULSE;
                end
            end
            ssd_pkg::ST_PULSE: begin
                if (cnt_zero) begin
                    pins_next.ce_n = 1'b1;
                    pins_next.oe_n = 1'b1;
                    cnt_next = ssd_pkg::READ_CYCLES;
                    state_next = ssd_pkg::ST_GAP;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ssd_pkg::ST_GAP: begin
                if (!cnt_zero) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (!last_step) begin
                    step_next = step_reg + 3'h1;
                    state_next = ssd_pkg::ST_WAIT;
                end else if (!store_reg) begin
                    store_next = 1'b1;
                    step_next = 3'h0;
                    state_next = ssd_pkg::ST_WAIT;
                end else begin
                    state_next = ssd_pkg::ST_DONE;
                end
            end
            ssd_pkg::ST_DONE: begin
                if (hardware_store_busy_n) begin
                    done_next = 1'b1;
                    state_next = ssd_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = ssd_pkg::ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ssd_pkg::ST_IDLE;
            step_reg <= 3'h0;
            cnt_reg <= 4'h0;
            enable_reg <= 1'b1;
            store_reg <= 1'b0;
            done_reg <= 1'b0;
            pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
        end else if (clk_en) begin
            state_reg <= state_next;
            step_reg <= step_next;
            cnt_reg <= cnt_next;
            enable_reg <= enable_next;
            store_reg <= store_next;
            done_reg <= done_next;
            pins_reg <= pins_next;
        end
    end

    // ************************************************************
    // Check helpers
    // ************************************************************
    // Enabled cycles with the chip selected and deselected; counting them here keeps the
    // length checks free of long repetitions.
    logic [4:0] low_len_reg;
    logic [4:0] high_len_reg;
    wire        high_len_full = (high_len_reg == 5'h1F);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            low_len_reg <= 5'h00;
            high_len_reg <= 5'h00;
        end else if (clk_en) begin
            low_len_reg <= pins_reg.ce_n ? 5'h00 : low_len_reg + 5'h01;
            high_len_reg <= !pins_reg.ce_n ? 5'h00 : (high_len_full ? high_len_reg : high_len_reg + 5'h01);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_we_stays_high: assert property (@(posedge clk_sys) disable iff (!resetn)
        sram_pins.we_n) else $error("write enable dropped during sequence");
    chk_read_has_oe: assert property (@(posedge clk_sys) disable iff (!resetn)
        !sram_pins.ce_n |-> !sram_pins.oe_n) else $error("chip enable without output enable");
    chk_first_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($fell(sram_pins.ce_n) && step_reg == 3'h0) |-> sram_pins.addr[15:0] == 16'h4E38)
        else $error("first step address wrong");
    chk_final_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($fell(sram_pins.ce_n) && step_reg == 3'h5 && !store_reg && !enable_reg)
        |-> sram_pins.addr[15:0] == 16'h8B45) else $error("disable address wrong");
    chk_enable_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($fell(sram_pins.ce_n) && step_reg == 3'h5 && !store_reg && enable_reg)
        |-> sram_pins.addr[15:0] == 16'h4B46) else $error("enable address wrong");
    chk_store_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && state_reg == ssd_pkg::ST_GAP && cnt_zero && last_step && !store_reg)
        |=> store_reg && step_reg == 3'h0) else $error("store not started after mode change");
    chk_addr_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!sram_pins.ce_n && !$past(sram_pins.ce_n)) |-> $stable(sram_pins.addr))
        else $error("address moved during read");
    chk_pulse_width: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && $fell(sram_pins.ce_n)) |-> cnt_reg == ssd_pkg::READ_CYCLES)
        else $error("read pulse length wrong");
    chk_prefix_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(sram_pins.ce_n) |-> (step_reg != 3'h1 || sram_pins.addr[15:0] == 16'hB1C7)
            && (step_reg != 3'h2 || sram_pins.addr[15:0] == 16'h83E0)
            && (step_reg != 3'h3 || sram_pins.addr[15:0] == 16'h7C1F)
            && (step_reg != 3'h4 || sram_pins.addr[15:0] == 16'h703F))
        else $error("prefix address out of order");
    chk_store_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($fell(sram_pins.ce_n) && step_reg == 3'h5 && store_reg)
        |-> sram_pins.addr[15:0] == 16'h8FC0) else $error("store address wrong");
    chk_read_length: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(sram_pins.ce_n) |-> low_len_reg == 5'(ssd_pkg::READ_CYCLES) + 5'h01)
        else $error("chip select held for wrong length");
    chk_gap_length: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($fell(sram_pins.ce_n) && step_reg != 3'h0) |-> high_len_reg >= 5'(ssd_pkg::READ_CYCLES) + 5'h02)
        else $error("deselect gap too short");
    chk_waits_busy: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(sram_pins.ce_n) |-> $past(hardware_store_busy_n))
        else $error("read started while device busy");
    chk_select_in_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ssd_pkg::ST_PULSE) == !sram_pins.ce_n)
        else $error("chip selected outside a read");
    chk_idle_deselected: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmd_ready |-> (sram_pins.ce_n && sram_pins.oe_n && sram_pins.we_n))
        else $error("bus not released while idle");
    chk_mode_held: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg != ssd_pkg::ST_IDLE && $past(state_reg) != ssd_pkg::ST_IDLE)
        |-> $stable(enable_reg)) else $error("requested mode changed during job");
    chk_done_after_store: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(cmd_done) |-> (store_reg && last_step))
        else $error("job ended without store sequence");
endmodule // ssd_host

// >>> bench/ssd_sram_model.sv
// Behavioural SRAM partner that decodes the six-read mode sequences.
// Assumes pins are registered on clk_sys by the host and only the host drives them.
module ssd_sram_model #(
    parameter int BUSY_CYC = 50
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  supply_low,
    input  ssd_pkg::ssd_pins_type      sram_pins,
    output logic                       hardware_store_busy_n,
    output logic [15:0]                sram_dq_out,
    output logic                       pd_store_en,
    output logic                       stored_en,
    output logic [7:0]                 reads_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Sequence decode
    // ************************************************************
    logic        ce_q;
    logic [2:0]  step_reg;
    logic [7:0]  busy_cnt;
    logic [15:0] want;
    wire         start = ce_q & ~sram_pins.ce_n;
    assign want = step_reg == 3'h0 ? ssd_pkg::SEQ_ADDR_0 : step_reg == 3'h1 ? ssd_pkg::SEQ_ADDR_1 :
                  step_reg == 3'h2 ? ssd_pkg::SEQ_ADDR_2 : step_reg == 3'h3 ? ssd_pkg::SEQ_ADDR_3 :
                  ssd_pkg::SEQ_ADDR_4;
    assign hardware_store_busy_n = (busy_cnt == 8'h00);
    // Released bus shows the inverted address, never the last driven value.
    assign sram_dq_out = (sram_pins.ce_n | sram_pins.oe_n) ? ~sram_pins.addr[15:0] : sram_pins.addr[15:0];
    function automatic logic hit(input logic [15:0] v);
        return sram_pins.addr[14:2] == v[14:2];
    endfunction
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ce_q <= 1'b1;
            step_reg <= 3'h0;
            busy_cnt <= 8'h1E;
            pd_store_en <= 1'b1;
            stored_en <= 1'b1;
            reads_seen <= 8'h00;
        end else begin
            ce_q <= sram_pins.ce_n;
            if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
            if (!sram_pins.ce_n && !sram_pins.we_n) begin
                step_reg <= 3'h0;
            end else if (start && busy_cnt == 8'h00) begin
                reads_seen <= reads_seen + 8'h01;
                if (step_reg == 3'h5) begin
                    step_reg <= 3'h0;
                    if (hit(ssd_pkg::SEQ_ADDR_DIS)) pd_store_en <= 1'b0;
                    if (hit(ssd_pkg::SEQ_ADDR_EN)) pd_store_en <= 1'b1;
                    if (hit(ssd_pkg::SEQ_ADDR_STORE) && !supply_low) begin
                        stored_en <= pd_store_en;
                        busy_cnt <= 8'(BUSY_CYC);
                    end
                end else begin
                    step_reg <= hit(want) ? step_reg + 3'h1 : (hit(ssd_pkg::SEQ_ADDR_0) ? 3'h1 : 3'h0);
                end
            end
        end
    end
endmodule // ssd_sram_model

// >>> bench/tb_ssd_host.sv
// Self-checking bench for the store-mode sequence host.
// Assumes the partner model above stands for the SRAM.
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_ssd_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1, cmd_valid = 1'b0, cmd_enable = 1'b0, supply_low = 1'b0;
    logic cmd_ready, cmd_done, busy_n, as_en, st_en;
    logic [15:0] dq;
    logic [7:0] reads;
    ssd_pkg::ssd_pins_type pins, held;
    int miscompares = 0, n_tests = 0, we_low = 0;
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (resetn && pins.we_n !== 1'b1) we_low++;
    ssd_host u_dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd_enable(cmd_enable), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .hardware_store_busy_n(busy_n), .sram_pins(pins), .sram_dq_in(dq));
    ssd_sram_model u_mem (.clk_sys(clk_sys), .resetn(resetn), .sram_pins(pins), .hardware_store_busy_n(busy_n),
        .sram_dq_out(dq), .pd_store_en(as_en), .stored_en(st_en), .reads_seen(reads), .supply_low(supply_low));
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check_reset();
        `CHK(cmd_ready, 1'b1, "ready after reset")
        `CHK({pins.ce_n, pins.oe_n, pins.we_n, cmd_done}, 4'hE, "pins after reset")
        `CHK(as_en, 1'b1, "initial power-down store")
        $display("test reset done");
    endtask
    task automatic run_job(input logic en, input logic freeze, input logic low);
        int i;
        logic [7:0] r0;
        logic s0;
        r0 = reads;
        s0 = st_en;
        @(posedge clk_sys) cmd_valid <= 1'b1;
        cmd_enable <= en;
        supply_low <= low;
        @(posedge clk_sys) cmd_valid <= 1'b0;
        #1 `CHK(cmd_ready, 1'b0, "ready stays high after take")
        if (freeze) begin
            repeat (40) @(posedge clk_sys);
            clk_en <= 1'b0;
            @(posedge clk_sys) #1 held = pins;
            repeat (10) @(posedge clk_sys);
            #1 `CHK(pins, held, "pins move while frozen")
            @(posedge clk_sys) clk_en <= 1'b1;
        end
        for (i = 0; i < 3000 && cmd_done !== 1'b1; i++) @(posedge clk_sys) #1;
        if (i == 3000) begin
            miscompares++;
            $display("CHECK FAILED t=%0t job hung", $time);
            tally_and_finish();
        end
        `CHK(8'(reads - r0), 8'h0C, "reads per job")
        `CHK(as_en, en, "mode after sequence")
        `CHK(st_en, low ? s0 : en, "mode not stored")
        `CHK(we_low, 0, "write enable driven low")
        @(posedge clk_sys) #1 `CHK(cmd_done, 1'b0, "done longer than one cycle")
        `CHK(cmd_ready, 1'b1, "ready after done")
        $display("test job en=%0b freeze=%0b low=%0b done", en, freeze, low);
    endtask
    task automatic reset_mid_job();
        @(posedge clk_sys) cmd_valid <= 1'b1;
        cmd_enable <= 1'b0;
        @(posedge clk_sys) cmd_valid <= 1'b0;
        repeat (60) @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys) #1 check_reset();
        $display("test reset during job done");
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys) #1 check_reset();
        run_job(1'b0, 1'b0, 1'b0);
        run_job(1'b1, 1'b1, 1'b0);
        reset_mid_job();
        run_job(1'b0, 1'b0, 1'b0);
        run_job(1'b1, 1'b0, 1'b1);
        tally_and_finish();
    end
endmodule // tb_ssd_host
